// *** phy_link_mode_control.sv ***
// Purpose: link mode control of a 10/100 twisted pair PHY
// Assumes: line and mac inputs are on clk; the two pins are not
// Notes: APB slave, one wait state on every access
//
// Operation
// R1: without FLP bursts, infer speed from MLT-3 or NLPs, assume half duplex
// R2: link formed by parallel detection clears expansion bit 0
// R3: fault during parallel detection sets expansion bit 4
// R4: partner ability register holds the decoded FLP word
// R5: after parallel detection, partner ability shows the detected speed
// R6: software sets control bit 9 to restart negotiation
// R7: loss of received signal restarts negotiation
// R8: commanded restart halts traffic for the break link time first
// R9: control bit 12 low forces speed from bit 13, duplex from bit 8
// R10: forced speed and duplex bits ignored while negotiation enabled
// R11: half duplex carrier sense follows transmit and receive
// R12: half duplex reports collision on receive while transmitting
// R13: full duplex carrier sense follows receive only, no collision
// R14: full duplex transmitting keeps carrier sense low
// R15: active carrier sense is high while line carrier is detected
// R16: no carrier status bit comes from internal carrier sense
// R17: host must not trust carrier status in full duplex
// R18: automatic crossover assigns pairs from the detected partner pairs
// R19: crossover disabled by mode bit 15 or the enable pin
// R20: with crossover off, the select pin assigns the pairs
// R21: negotiation picks 100 full, 100 half, 10 full, 10 half
// R22: crossover active only when register and pin both allow it
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module phy_link_mode_control
    import phy_link_pkg::*;
#(
    parameter int BREAK_CYCLES = `BREAK_LINK_MS * `CLK_KHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire apb_req_t apb_req,
    output var apb_rsp_t apb_rsp,
    input wire line_in_t line_in,
    input wire mac_in_t mac_in,
    input wire logic crossover_auto_enable_pin,
    input wire logic pair_swap_select_pin,
    output var mac_out_t mac_out,
    output var link_out_t link_out
);

    state_t cur_ff;
    state_t nxt_st;

    localparam logic [`TIMER_W-1:0] BREAK_LOAD = `TIMER_W'(BREAK_CYCLES);

    // returns {ok, speed_100, full_duplex} for the best common mode
    function automatic logic [2:0] resolve(input logic [3:0] common);
        logic [2:0] r;
        r = 3'h0;
        if (common[3]) begin
            r = 3'h7; // R21
        end else if (common[2]) begin
            r = 3'h6;
        end else if (common[1]) begin
            r = 3'h5;
        end else if (common[0]) begin
            r = 3'h4;
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        return addr[7:2] == idx;
    endfunction

    logic acc;
    logic done;
    logic [5:0] ridx;
    logic [15:0] rd;
    logic mapped;
    logic [2:0] res;
    logic xover_on;
    logic half;
    logic crs_n;
    logic [15:0] lpa_pd;

    always_comb begin
        nxt_st = cur_ff;
        acc = apb_req.psel && apb_req.penable;
        done = acc && cur_ff.rsp.pready;
        ridx = apb_req.paddr[7:2];
        rd = 16'h0;
        mapped = 1'b1;
        res = 3'h0;
        lpa_pd = 16'h0;

        // two-stage synchronisers for the pins
        nxt_st.xpin_s1 = crossover_auto_enable_pin;
        nxt_st.xpin_s2 = cur_ff.xpin_s1;
        nxt_st.sel_s1 = pair_swap_select_pin;
        nxt_st.sel_s2 = cur_ff.sel_s1;

        // register read mux
        if (hit(apb_req.paddr, `REG_CTRL_IDX)) begin
            rd = cur_ff.ctrl;
            rd[`CTRL_RESTART_BIT] = 1'b0;
        end else if (hit(apb_req.paddr, `REG_ADV_IDX)) begin
            rd[`ADV_LSB +: 4] = cur_ff.adv;
        end else if (hit(apb_req.paddr, `REG_LPA_IDX)) begin
            rd = cur_ff.lpa;
        end else if (hit(apb_req.paddr, `REG_EXP_IDX)) begin
            rd[`EXP_LP_AN_BIT] = cur_ff.lp_an_able;
            rd[`EXP_PD_FAULT_BIT] = cur_ff.pd_fault;
        end else if (hit(apb_req.paddr, `REG_MODE_IDX)) begin
            rd[`MODE_XOVER_DIS_BIT] = cur_ff.xover_dis;
        end else if (hit(apb_req.paddr, `REG_STAT_IDX)) begin
            rd = {11'h0, cur_ff.link.swap_pairs, cur_ff.link.halt,
                  cur_ff.link.full_duplex, cur_ff.link.speed_100,
                  cur_ff.link.link_up};
        end else begin
            mapped = 1'b0;
        end

        // one wait state: answer in the second access cycle
        nxt_st.rsp.pready = acc && !cur_ff.rsp.pready;
        if (acc && !cur_ff.rsp.pready) begin
            nxt_st.rsp.prdata = apb_req.pwrite ? 32'h0 : {16'h0, rd};
            nxt_st.rsp.pslverr = !mapped;
        end else begin
            nxt_st.rsp.prdata = 32'h0;
            nxt_st.rsp.pslverr = 1'b0;
        end

        // writes take effect at the completing edge
        if (done && apb_req.pwrite) begin
            if (ridx == `REG_CTRL_IDX) begin
                nxt_st.ctrl = apb_req.pwdata[15:0];
            end
            if (ridx == `REG_ADV_IDX) begin
                nxt_st.adv = apb_req.pwdata[`ADV_LSB +: 4];
            end
            if (ridx == `REG_MODE_IDX) begin
                nxt_st.xover_dis = apb_req.pwdata[`MODE_XOVER_DIS_BIT]; // R19
            end
        end
        // fault bit clears on read of the expansion register
        if (done && !apb_req.pwrite && ridx == `REG_EXP_IDX) begin
            nxt_st.pd_fault = 1'b0;
        end

        // link mode machine
        if (cur_ff.timer != '0) begin
            nxt_st.timer = cur_ff.timer - `TIMER_W'(1);
        end
        case (cur_ff.mode)
            ST_BREAK: begin
                if (cur_ff.timer == '0) begin
                    nxt_st.mode = ST_NEG; // R8
                end
            end
            ST_NEG: begin
                if (line_in.word_valid) begin
                    nxt_st.lpa = line_in.word; // R4
                    nxt_st.lp_an_able = 1'b1;
                    res = resolve(cur_ff.adv & line_in.word[`ADV_LSB +: 4]);
                    if (res[2]) begin
                        nxt_st.mode = ST_LINK;
                        nxt_st.link.speed_100 = res[1]; // R21 R10
                        nxt_st.link.full_duplex = res[0];
                    end
                end else if (line_in.mlt3_seen || line_in.nlp_seen) begin
                    // R1
                    nxt_st.mode = ST_LINK;
                    nxt_st.link.speed_100 = line_in.mlt3_seen;
                    nxt_st.link.full_duplex = 1'b0;
                    nxt_st.lp_an_able = 1'b0; // R2
                    if (line_in.mlt3_seen) begin
                        lpa_pd[`LPA_100HD_BIT] = 1'b1;
                    end else begin
                        lpa_pd[`LPA_10HD_BIT] = 1'b1;
                    end
                    nxt_st.lpa = lpa_pd; // R5
                end
            end
            ST_LINK: begin
                if (!line_in.sig_detect) begin
                    nxt_st.mode = ST_NEG; // R7
                end
            end
            ST_FORCED: begin
                // R9
                nxt_st.link.speed_100 = cur_ff.ctrl[`CTRL_SPEED_BIT];
                nxt_st.link.full_duplex = cur_ff.ctrl[`CTRL_DUPLEX_BIT];
                if (cur_ff.ctrl[`CTRL_AN_EN_BIT]) begin
                    nxt_st.mode = ST_NEG;
                end
            end
            default: begin
                nxt_st.mode = ST_NEG;
            end
        endcase

        // negotiation off overrides everything; R10 ignores forced bits
        if (!cur_ff.ctrl[`CTRL_AN_EN_BIT]) begin
            nxt_st.mode = ST_FORCED; // R9
            nxt_st.timer = '0;
        end else if (cur_ff.ctrl[`CTRL_RESTART_BIT]) begin
            nxt_st.mode = ST_BREAK; // R6
            nxt_st.timer = BREAK_LOAD; // R8
            nxt_st.ctrl[`CTRL_RESTART_BIT] = 1'b0;
        end

        // fault sets after any clear above, so the set wins
        if (cur_ff.mode == ST_NEG && !line_in.word_valid && line_in.pd_fault) begin
            nxt_st.pd_fault = 1'b1; // R3
        end

        nxt_st.link.link_up = (nxt_st.mode == ST_LINK) ||
            (nxt_st.mode == ST_FORCED && line_in.sig_detect);
        nxt_st.link.halt = nxt_st.mode == ST_BREAK; // R8

        // crossover needs both register and pin to allow it
        xover_on = !cur_ff.xover_dis && cur_ff.xpin_s2; // R22
        nxt_st.link.swap_pairs = xover_on ? line_in.partner_crossed // R18
                                          : cur_ff.sel_s2; // R20

        // carrier sense and collision
        half = !cur_ff.link.full_duplex;
        if (cur_ff.link.halt) begin
            crs_n = 1'b0;
            nxt_st.mac.col = 1'b0;
        end else if (half) begin
            crs_n = mac_in.tx_en || mac_in.carrier; // R11 R15
            nxt_st.mac.col = mac_in.tx_en && mac_in.carrier; // R12
        end else begin
            crs_n = mac_in.carrier && !mac_in.tx_en; // R13 R14
            nxt_st.mac.col = 1'b0; // R13
        end
        nxt_st.mac.crs = crs_n;

        // no carrier: loaded with inverted carrier sense at frame start, cleared once carrier sense is high while transmitting
        nxt_st.tx_prev = mac_in.tx_en;
        if (mac_in.tx_en && !cur_ff.tx_prev) begin
            nxt_st.mac.no_carrier = !crs_n; // R16
        end else if (mac_in.tx_en && crs_n) begin
            nxt_st.mac.no_carrier = 1'b0; // R16
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
            cur_ff.mode <= ST_NEG;
            cur_ff.ctrl <= `CTRL_RESET_VAL;
            cur_ff.adv <= `ADV_RESET_VAL;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign apb_rsp = cur_ff.rsp;
    assign mac_out = cur_ff.mac;
    assign link_out = cur_ff.link;

endmodule // phy_link_mode_control
`default_nettype wire

// *** phy_link_params.svh ***
// Purpose: constants of the link mode control block
// Assumes: register index times four gives the APB byte address
// Notes: timing figures are kept in their own units
`ifndef PHY_LINK_PARAMS_SVH
`define PHY_LINK_PARAMS_SVH

`define CLK_KHZ 40000
`define BREAK_LINK_MS 1200
`define TIMER_W 26

`define REG_CTRL_IDX 6'd0
`define REG_ADV_IDX 6'd4
`define REG_LPA_IDX 6'd5
`define REG_EXP_IDX 6'd6
`define REG_MODE_IDX 6'd27
`define REG_STAT_IDX 6'd31

`define CTRL_DUPLEX_BIT 8
`define CTRL_RESTART_BIT 9
`define CTRL_AN_EN_BIT 12
`define CTRL_SPEED_BIT 13
`define CTRL_RESET_VAL 16'h3100

`define ADV_LSB 5
`define ADV_RESET_VAL 4'hf
`define LPA_10HD_BIT 5
`define LPA_100HD_BIT 7

`define EXP_LP_AN_BIT 0
`define EXP_PD_FAULT_BIT 4
`define MODE_XOVER_DIS_BIT 15

`endif

// *** phy_link_pkg.sv ***
// Purpose: types shared by the link mode control block
// Assumes: nothing beyond the params header
// Notes: all state of the block lives in one packed struct
`default_nettype none
package phy_link_pkg;
`include "phy_link_params.svh"

    typedef enum logic [1:0] {
        ST_BREAK = 2'b00,
        ST_NEG = 2'b01,
        ST_LINK = 2'b10,
        ST_FORCED = 2'b11
    } mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic sig_detect;
        logic mlt3_seen;
        logic nlp_seen;
        logic pd_fault;
        logic word_valid;
        logic [15:0] word;
        logic partner_crossed;
    } line_in_t;

    typedef struct packed {
        logic tx_en;
        logic carrier;
    } mac_in_t;

    typedef struct packed {
        logic crs;
        logic col;
        logic no_carrier;
    } mac_out_t;

    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic halt;
        logic swap_pairs;
    } link_out_t;

    typedef struct packed {
        mode_t mode;
        logic [`TIMER_W-1:0] timer;
        logic [15:0] ctrl;
        logic [3:0] adv;
        logic [15:0] lpa;
        logic lp_an_able;
        logic pd_fault;
        logic xover_dis;
        logic xpin_s1;
        logic xpin_s2;
        logic sel_s1;
        logic sel_s2;
        logic tx_prev;
        mac_out_t mac;
        link_out_t link;
        apb_rsp_t rsp;
    } state_t;

endpackage
`default_nettype wire

// *** link_partner.sv ***
// Purpose: remote twisted pair partner feeding the line side
// Assumes: kind changes right after a rising edge
// Notes: idle word lines toggle so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module link_partner
    import phy_link_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] kind,
    input wire logic [15:0] word,
    input wire logic crossed,
    input wire logic fault,
    output var line_in_t line
);
    logic [1:0] kind_ff = 2'h0;
    logic [15:0] junk_ff = 16'h0;
    always_ff @(posedge clk) begin
        kind_ff <= kind;
        junk_ff <= ~junk_ff;
    end
    always_comb begin
        line.sig_detect = kind != 2'h0;
        line.word_valid = kind == 2'h1 && kind_ff != 2'h1;
        line.word = line.word_valid ? word : junk_ff;
        line.mlt3_seen = kind == 2'h2;
        line.nlp_seen = kind == 2'h3;
        line.pd_fault = fault;
        line.partner_crossed = crossed;
    end
endmodule // link_partner
`default_nettype wire

// *** phy_link_mode_control_props.sv ***
// Purpose: port checks of the link mode control block
// Assumes: BREAK_CYCLES of at least 8
// Notes: mac outputs are judged one cycle after their causes
`timescale 1ns/1ps
`default_nettype none
module phy_link_mode_control_props
    import phy_link_pkg::*;
#(
    parameter int BREAK_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire line_in_t line_in,
    input wire mac_in_t mac_in,
    input wire logic crossover_auto_enable_pin,
    input wire logic pair_swap_select_pin,
    input wire mac_out_t mac_out,
    input wire link_out_t link_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence restart_s;
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
            && apb_req.paddr == 8'h00 && apb_req.pwdata[9] && apb_req.pwdata[12];
    endsequence
    sequence quiet_s;
        link_out.halt [*8];
    endsequence
    a_restart_halt: assert property (restart_s |-> ##[1:3] quiet_s)
        else $error("restart did not halt");
    a_halt_quiet: assert property (link_out.halt |=> !mac_out.crs && !mac_out.col)
        else $error("traffic during halt");
    a_half_col: assert property (!link_out.full_duplex && !link_out.halt &&
        mac_in.tx_en && mac_in.carrier |=> mac_out.col)
        else $error("collision missed");
    a_half_tx: assert property (!link_out.full_duplex && !link_out.halt &&
        mac_in.tx_en |=> mac_out.crs)
        else $error("crs missing on transmit");
    a_full_tx: assert property (link_out.full_duplex && mac_in.tx_en |=>
        !mac_out.crs && !mac_out.col)
        else $error("crs or col in full duplex transmit");
    a_rx_crs: assert property (!link_out.halt && mac_in.carrier &&
        !(link_out.full_duplex && mac_in.tx_en) |=> mac_out.crs)
        else $error("crs missing on receive");
    a_sig_loss: assert property (!line_in.sig_detect |-> ##[1:3] !link_out.link_up)
        else $error("link kept without signal");
    a_pin_swap: assert property ((!crossover_auto_enable_pin &&
        pair_swap_select_pin) [*4] |-> link_out.swap_pairs)
        else $error("select pin ignored");
endmodule // phy_link_mode_control_props
bind phy_link_mode_control phy_link_mode_control_props #(.BREAK_CYCLES(BREAK_CYCLES)) u_props (
    .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .line_in(line_in),
    .mac_in(mac_in), .crossover_auto_enable_pin(crossover_auto_enable_pin),
    .pair_swap_select_pin(pair_swap_select_pin), .mac_out(mac_out), .link_out(link_out)
);
`default_nettype wire

// *** phy_link_mode_control_test.sv ***
// Purpose: scenario bench of the link mode control block
// Assumes: short break time through BREAK_CYCLES
// Notes: link and mac outputs are read on the falling edge except in the reg off check, the APB response right after the rising edge
`timescale 1ns/1ps
`default_nettype none
module phy_link_mode_control_test
    import phy_link_pkg::*;
;
    localparam int BRK = 20;
    localparam logic [15:0] ABIL = 16'h135f;
    logic clk = 1'b0;
    logic rst = 1'b1;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    line_in_t line;
    mac_in_t mac = '0;
    logic xen = 1'b1;
    logic xsel = 1'b0;
    mac_out_t mo;
    link_out_t lo;
    logic [1:0] kind = 2'h0;
    logic [15:0] word = 16'h0;
    logic crossed = 1'b0;
    logic fault = 1'b0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int total_checks = 0;
    phy_link_mode_control #(.BREAK_CYCLES(BRK)) u_dut (.clk(clk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .line_in(line), .mac_in(mac), .crossover_auto_enable_pin(xen),
        .pair_swap_select_pin(xsel), .mac_out(mo), .link_out(lo));
    link_partner u_partner (.clk(clk), .kind(kind), .word(word), .crossed(crossed),
        .fault(fault), .line(line));
    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        // values seen right after the edge are those the edge sampled
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n >= 20) begin
            chk("pready", 32'h1, 32'h0);
            finish_test();
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic wait_link();
        int n;
        n = 0;
        while (lo.link_up !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            chk("link_up", 32'h1, 32'h0);
            finish_test();
        end
    endtask
    task automatic t_regs();
        rchk("ctrl", 8'h00, 32'h3100);
        rchk("adv", 8'h10, 32'h1e0);
        apb(1'b1, 8'h40, 32'hffff);
        chk("unmapped err", 32'h1, {31'h0, err});
        @(posedge clk);
        fault <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        rchk("fault set", 8'h18, 32'h10);
        rchk("fault read clear", 8'h18, 32'h0);
    endtask
    task automatic t_pd();
        for (int k = 2; k < 4; k++) begin
            @(posedge clk);
            kind <= 2'h0;
            cyc(3);
            kind <= k[1:0];
            wait_link();
            chk("pd mode", {30'h0, k == 2, 1'b0}, {30'h0, lo.speed_100, lo.full_duplex});
            rchk("pd ability", 8'h14, (k == 2) ? 32'h80 : 32'h20);
            rchk("pd expansion", 8'h18, 32'h0);
        end
    endtask
    task automatic t_neg();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            kind <= 2'h0;
            word <= {7'h0, ABIL[4*k +: 4], 5'h01};
            cyc(3);
            kind <= 2'h1;
            @(negedge clk);
            chk("link lost", 32'h0, {31'h0, lo.link_up});
            wait_link();
            chk("neg mode", 32'(3 - k), {30'h0, lo.speed_100, lo.full_duplex});
            rchk("neg ability", 8'h14, {23'h0, ABIL[4*k +: 4], 5'h01});
        end
        rchk("neg expansion", 8'h18, 32'h1);
    endtask
    task automatic crs_case(input logic full);
        @(posedge clk);
        mac <= '{1'b1, 1'b0};
        cyc(3);
        @(negedge clk);
        chk("tx crs", {31'h0, !full}, {31'h0, mo.crs});
        chk("no carrier", {31'h0, full}, {31'h0, mo.no_carrier});
        @(posedge clk);
        mac <= '{1'b1, 1'b1};
        cyc(2);
        @(negedge clk);
        chk("collision", {31'h0, !full}, {31'h0, mo.col});
        @(posedge clk);
        mac <= '{1'b0, 1'b1};
        cyc(2);
        @(negedge clk);
        chk("rx crs", 32'h1, {31'h0, mo.crs});
        @(posedge clk);
        mac <= '0;
    endtask
    task automatic t_forced();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h00, {18'h0, k[1], 4'h0, k[0], 8'h0});
            cyc(3);
            @(negedge clk);
            chk("forced mode", 32'(k), {30'h0, lo.speed_100, lo.full_duplex});
            crs_case(k[0]);
        end
    endtask
    task automatic t_restart();
        int hi;
        hi = 0;
        apb(1'b1, 8'h00, 32'h3300);
        repeat (60) begin
            @(negedge clk);
            hi += (lo.halt === 1'b1);
        end
        chk("halt cycles", BRK + 1, hi);
        rchk("restart clears", 8'h00, 32'h3100);
    endtask
    task automatic t_xover();
        @(posedge clk);
        crossed <= 1'b1;
        cyc(4);
        @(negedge clk);
        chk("auto swap", 32'h1, {31'h0, lo.swap_pairs});
        apb(1'b1, 8'h6c, 32'h8000);
        rchk("mode reg", 8'h6c, 32'h8000);
        chk("reg off", 32'h0, {31'h0, lo.swap_pairs});
        apb(1'b1, 8'h6c, 32'h0);
        xen <= 1'b0;
        xsel <= 1'b1;
        cyc(4);
        @(negedge clk);
        chk("pin off", 32'h1, {31'h0, lo.swap_pairs});
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_pd();
        t_neg();
        t_forced();
        t_restart();
        t_xover();
        finish_test();
    end
endmodule // phy_link_mode_control_test
`default_nettype wire
